// File: design/cdma_buf.v
// Purpose: Word buffer between the DMA engine and the card data path
// Assumes: Caller never pushes when full nor pops when empty
// Notes:   Flip-flop storage addressed by wrapping indices
`timescale 1ns/1ps
`include "cdma_regs.vh"

module cdma_buf (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_reset_n,
  // Fill side
  input  wire        i_push,
  input  wire [31:0] i_data,
  // Drain side
  input  wire        i_pop,
  output wire [31:0] o_data,
  // Level
  output wire        o_full,
  output wire        o_near_full,
  output wire        o_empty
);

  reg [31:0]               store [0:(1 << `CDMA_BUF_AW) - 1];
  reg [`CDMA_BUF_AW-1:0]   wr_idx;
  reg [`CDMA_BUF_AW-1:0]   rd_idx;
  reg [`CDMA_BUF_AW:0]     level;

  assign o_data      = store[rd_idx];
  assign o_full      = (level == `CDMA_BUF_DEPTH);
  assign o_near_full = (level >= `CDMA_BUF_NEAR);
  assign o_empty     = (level == {(`CDMA_BUF_AW + 1){1'b0}});

  always @(posedge i_mclk) begin
    if (i_push) begin
      store[wr_idx] <= i_data;
    end
  end

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_idx <= {`CDMA_BUF_AW{1'b0}};
      rd_idx <= {`CDMA_BUF_AW{1'b0}};
      level  <= {(`CDMA_BUF_AW + 1){1'b0}};
    end else begin
      if (i_push) begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (i_pop) begin
        rd_idx <= rd_idx + 1'b1;
      end
      if (i_push && !i_pop) begin
        level <= level + 1'b1;
      end else if (i_pop && !i_push) begin
        level <= level - 1'b1;
      end
    end
  end

endmodule

// File: design/cdma_engine.v
// Purpose: Descriptor-driven DMA between host memory and card buffers
// Assumes: Single-beat memory bus, request held until acknowledge
// Notes:   Data port reaches the buffers only while the engine is idle
//
// Functional notes
// - Owner bit set means engine owns entry
// - Word0 bit 30 reports ORed card faults
// - Ring wrap flag returns to list base
// - Pointer mode uses word3 as next entry
// - Empty first buffer defers data to next entry
// - Final entry flags count error unless transfer count is zero
// - Completion mask suppresses transmit/receive done flags
// - Word2 is full 32-bit buffer address
// - Each entry is four consecutive words
// - Entries chain buffer to buffer
// - Transmit buffer fed by port or engine
// - Receive buffer drained by port or engine
// - Unowned entry suspends and flags unavailable
// - Poll demand kick refetches and resumes
// - Wait command done and transfer request
`timescale 1ns/1ps
`include "cdma_regs.vh"

module cdma_engine (
  // Clock and reset
  input  wire                    i_mclk,
  input  wire                    i_reset_n,
  // Engine control
  input  wire                    i_dma_start,
  input  wire [31:0]             i_list_base,
  input  wire [31:0]             i_byte_count,
  input  wire                    i_dir_rx,
  input  wire                    i_poll_demand_kick,
  input  wire                    i_done_clear,
  input  wire                    i_unavail_clear,
  // Controller status
  input  wire                    i_cmd_done,
  input  wire                    i_cmd_error,
  input  wire                    i_transfer_request,
  input  wire [`CDMA_NFAULT-1:0] i_raw_card_events,
  // Register data port
  input  wire                    i_send_enable,
  input  wire                    i_port_wr,
  input  wire [31:0]             i_port_wdata,
  input  wire                    i_port_rd,
  output reg  [31:0]             o_port_rdata,
  // Host memory master
  output reg                     o_mem_req,
  output reg                     o_mem_we,
  output reg  [31:0]             o_mem_addr,
  output reg  [31:0]             o_mem_wdata,
  input  wire                    i_mem_ack,
  input  wire [31:0]             i_mem_rdata,
  // Card data path
  output reg                     o_card_tx_valid,
  output reg  [31:0]             o_card_tx_data,
  input  wire                    i_card_tx_ready,
  input  wire                    i_card_rx_valid,
  input  wire [31:0]             i_card_rx_data,
  output reg                     o_card_rx_ready,
  // Status
  output reg                     o_busy,
  output reg                     o_suspended,
  output reg                     o_tx_done_flag,
  output reg                     o_rx_done_flag,
  output reg                     o_desc_unavail,
  output reg                     o_count_error,
  output wire                    o_card_fault_summary
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_FETCH = 7'h02;
  localparam [6:0] ST_CHECK = 7'h04;
  localparam [6:0] ST_WCMD  = 7'h08;
  localparam [6:0] ST_XFER  = 7'h10;
  localparam [6:0] ST_WBACK = 7'h20;
  localparam [6:0] ST_SUSP  = 7'h40;

  reg [6:0]               state;
  reg [1:0]               word_idx;
  reg [31:0]              w0;
  reg [31:0]              w1;
  reg [31:0]              w3;
  reg [31:0]              list_base;
  reg [31:0]              entry_addr;
  reg [31:0]              buf_addr;
  reg [`CDMA_SIZE_MSB:0]  entry_left;
  reg [31:0]              xfer_left;
  reg                     fault_clear;

  wire [31:0] tx_head;
  wire [31:0] rx_head;
  wire        tx_full;
  wire        tx_empty;
  wire        rx_near;
  wire        rx_empty;

  function [31:0] step_addr;
    input [31:0] base;
    input [31:0] step;
    begin
      step_addr = base + step;
    end
  endfunction

  // ----------------------------------------------------------------
  // Buffer traffic
  // ----------------------------------------------------------------
  wire mem_done   = o_mem_req && i_mem_ack;
  wire dma_push   = state[4] && !i_dir_rx && mem_done;
  wire port_push  = !o_busy && i_port_wr && i_send_enable && !tx_full;
  wire tx_push    = dma_push || port_push;
  wire tx_load    = !tx_empty && (!o_card_tx_valid || i_card_tx_ready);
  wire rx_push    = i_card_rx_valid && o_card_rx_ready;
  wire beat_go    = state[4] && !o_mem_req && i_transfer_request &&
                    (i_dir_rx ? !rx_empty : !tx_full);
  wire dma_pop    = beat_go && i_dir_rx;
  wire port_pop   = !o_busy && i_port_rd && !rx_empty;
  wire rx_pop     = dma_pop || port_pop;

  cdma_buf u_tx_buf (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_push      (tx_push),
    .i_data      (dma_push ? i_mem_rdata : i_port_wdata),
    .i_pop       (tx_load),
    .o_data      (tx_head),
    .o_full      (tx_full),
    .o_near_full (),
    .o_empty     (tx_empty)
  );

  cdma_buf u_rx_buf (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_push      (rx_push),
    .i_data      (i_card_rx_data),
    .i_pop       (rx_pop),
    .o_data      (rx_head),
    .o_full      (),
    .o_near_full (rx_near),
    .o_empty     (rx_empty)
  );

  cdma_fault u_fault (
    .i_mclk               (i_mclk),
    .i_reset_n            (i_reset_n),
    .i_clear              (fault_clear),
    .i_raw_card_events    (i_raw_card_events),
    .o_card_fault_summary (o_card_fault_summary)
  );

  // ----------------------------------------------------------------
  // Card side staging
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_card_tx_valid <= 1'b0;
      o_card_tx_data  <= 32'h0000_0000;
      o_card_rx_ready <= 1'b0;
      o_port_rdata    <= 32'h0000_0000;
    end else begin
      if (tx_load) begin
        o_card_tx_valid <= 1'b1;
        o_card_tx_data  <= tx_head;
      end else if (i_card_tx_ready) begin
        o_card_tx_valid <= 1'b0;
      end
      // One word of slack covers the registered ready
      o_card_rx_ready <= !rx_near;
      if (port_pop) begin
        o_port_rdata <= rx_head;
      end
    end
  end

  // ----------------------------------------------------------------
  // List walker
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state          <= ST_IDLE;
      word_idx       <= 2'h0;
      w0             <= 32'h0000_0000;
      w1             <= 32'h0000_0000;
      w3             <= 32'h0000_0000;
      list_base      <= 32'h0000_0000;
      entry_addr     <= 32'h0000_0000;
      buf_addr       <= 32'h0000_0000;
      entry_left     <= {`CDMA_SIZE_W{1'b0}};
      xfer_left      <= 32'h0000_0000;
      fault_clear    <= 1'b0;
      o_mem_req      <= 1'b0;
      o_mem_we       <= 1'b0;
      o_mem_addr     <= 32'h0000_0000;
      o_mem_wdata    <= 32'h0000_0000;
      o_busy         <= 1'b0;
      o_suspended    <= 1'b0;
      o_tx_done_flag <= 1'b0;
      o_rx_done_flag <= 1'b0;
      o_desc_unavail <= 1'b0;
      o_count_error  <= 1'b0;
    end else begin
      fault_clear <= 1'b0;
      if (mem_done) begin
        o_mem_req <= 1'b0;
      end
      // Set wins over clear on every sticky flag
      if (i_done_clear) begin
        o_tx_done_flag <= 1'b0;
        o_rx_done_flag <= 1'b0;
      end
      if (i_unavail_clear) begin
        o_desc_unavail <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (i_dma_start) begin
            list_base     <= i_list_base;
            entry_addr    <= i_list_base;
            xfer_left     <= i_byte_count;
            o_count_error <= 1'b0;
            word_idx      <= 2'h0;
            state         <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!o_mem_req) begin
            o_mem_req  <= 1'b1;
            o_mem_we   <= 1'b0;
            o_mem_addr <= step_addr(entry_addr, {28'h0000000, word_idx, 2'h0});
          end else if (i_mem_ack) begin
            case (word_idx)
              2'h0: w0 <= i_mem_rdata;
              2'h1: w1 <= i_mem_rdata;
              2'h2: buf_addr <= i_mem_rdata;
              default: w3 <= i_mem_rdata;
            endcase
            word_idx <= word_idx + 2'h1;
            if (word_idx == `CDMA_LAST_WORD) begin
              fault_clear <= 1'b1;
              state       <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          entry_left  <= w1[`CDMA_SIZE_MSB:0];
          if (!w0[`CDMA_OWN_BIT]) begin
            o_desc_unavail <= 1'b1;
            state          <= ST_SUSP;
          end else if (w1[`CDMA_SIZE_MSB:0] == {`CDMA_SIZE_W{1'b0}}) begin
            state <= ST_WBACK;
          end else begin
            state <= ST_WCMD;
          end
        end
        ST_WCMD: begin
          if (i_cmd_done && !i_cmd_error) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (beat_go) begin
            o_mem_req   <= 1'b1;
            o_mem_we    <= i_dir_rx;
            o_mem_addr  <= buf_addr;
            o_mem_wdata <= rx_head;
          end else if (mem_done) begin
            buf_addr   <= step_addr(buf_addr, `CDMA_WORD_STEP);
            entry_left <= entry_left - `CDMA_SIZE_STEP;
            xfer_left  <= step_addr(xfer_left, ~`CDMA_WORD_STEP + 32'h1);
            if (entry_left <= `CDMA_SIZE_STEP) begin
              state <= ST_WBACK;
            end
          end
        end
        ST_WBACK: begin
          if (!o_mem_req) begin
            o_mem_req   <= 1'b1;
            o_mem_we    <= 1'b1;
            o_mem_addr  <= entry_addr;
            o_mem_wdata <= {1'b0, o_card_fault_summary,
                            w0[`CDMA_RSVD_MSB:0]};
          end else if (i_mem_ack) begin
            word_idx <= 2'h0;
            if (w0[`CDMA_RING_BIT]) begin
              entry_addr <= list_base;
            end else if (w0[`CDMA_CHAIN_BIT]) begin
              entry_addr <= w3;
            end else begin
              entry_addr <= step_addr(entry_addr, `CDMA_ENTRY_STEP);
            end
            if (w0[`CDMA_FINAL_BIT]) begin
              if (!w0[`CDMA_MASK_BIT]) begin
                o_tx_done_flag <= !i_dir_rx | (o_tx_done_flag & !i_done_clear);
                o_rx_done_flag <= i_dir_rx | (o_rx_done_flag & !i_done_clear);
              end
              o_count_error <= (xfer_left != 32'h0000_0000);
              state         <= ST_IDLE;
            end else begin
              state <= ST_FETCH;
            end
          end
        end
        ST_SUSP: begin
          if (i_poll_demand_kick) begin
            word_idx <= 2'h0;
            state    <= ST_FETCH;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      o_busy      <= !state[0];
      o_suspended <= state[6];
    end
  end

endmodule

// File: design/cdma_fault.v
// Purpose: Card fault summary gathered over one list entry
// Assumes: Raw card events are levels or pulses in the clock domain
// Notes:   Cleared when a new entry starts, set wins over clear
`timescale 1ns/1ps
`include "cdma_regs.vh"

module cdma_fault (
  // Clock and reset
  input  wire                     i_mclk,
  input  wire                     i_reset_n,
  // Control
  input  wire                     i_clear,
  // Raw card events
  input  wire [`CDMA_NFAULT-1:0]  i_raw_card_events,
  // Summary
  output reg                      o_card_fault_summary
);

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_card_fault_summary <= 1'b0;
    end else if (|i_raw_card_events) begin
      o_card_fault_summary <= 1'b1;
    end else if (i_clear) begin
      o_card_fault_summary <= 1'b0;
    end
  end

endmodule

// File: pkg/cdma_regs.vh
// Purpose: Constants for the card host descriptor DMA engine
// Assumes: Four-word list entries in host memory, 32-bit words
// Notes:   Definitions only
`ifndef CDMA_REGS_VH
`define CDMA_REGS_VH

// ----------------------------------------------------------------
// List entry word 0 fields
// ----------------------------------------------------------------
`define CDMA_OWN_BIT      31
`define CDMA_FAULT_BIT    30
`define CDMA_RSVD_MSB     29
`define CDMA_RING_BIT     5
`define CDMA_CHAIN_BIT    4
`define CDMA_FIRST_BIT    3
`define CDMA_FINAL_BIT    2
`define CDMA_MASK_BIT     1

// ----------------------------------------------------------------
// List entry word 1 fields
// ----------------------------------------------------------------
`define CDMA_SIZE_MSB     12
`define CDMA_SIZE_W       13

// ----------------------------------------------------------------
// Address steps
// ----------------------------------------------------------------
`define CDMA_WORD_STEP    32'h0000_0004
`define CDMA_SIZE_STEP    13'h0004
`define CDMA_ENTRY_STEP   32'h0000_0010
`define CDMA_LAST_WORD    2'h3

// ----------------------------------------------------------------
// Data buffers and card fault inputs
// ----------------------------------------------------------------
`define CDMA_BUF_AW       3
`define CDMA_BUF_DEPTH    4'h8
`define CDMA_BUF_NEAR     4'h7
`define CDMA_NFAULT       7

`endif

// File: verification/card_host_descriptor_dma_tb_top.sv
// Purpose: Self-checking bench for the descriptor DMA engine
// Assumes: Host memory model answers the memory master
// Notes:   Card side is driven and captured here
`timescale 1ns/1ps
`include "cdma_regs.vh"

module card_host_descriptor_dma_tb_top;
  logic        i_mclk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_dma_start = 1'b0;
  logic [31:0] i_list_base = 32'h0;
  logic [31:0] i_byte_count = 32'h0;
  logic        i_dir_rx = 1'b0;
  logic        i_poll_demand_kick = 1'b0;
  logic        i_done_clear = 1'b0;
  logic        i_unavail_clear = 1'b0;
  logic        i_cmd_done = 1'b1;
  logic        i_cmd_error = 1'b0;
  logic        i_transfer_request = 1'b1;
  logic [6:0]  i_raw_card_events = 7'h0;
  logic        i_send_enable = 1'b0;
  logic        i_port_wr = 1'b0;
  logic [31:0] i_port_wdata = 32'h0;
  logic        i_port_rd = 1'b0;
  logic        i_card_tx_ready = 1'b1;
  logic        i_card_rx_valid = 1'b0;
  logic [31:0] i_card_rx_data = 32'hC0DE_0000;
  logic [1:0]  mem_wait = 2'h0;
  logic        stall = 1'b0;
  logic        rx_take = 1'b0;
  logic [31:0] exp;
  logic [31:0] txq [$];
  int          n_mismatch = 0;
  int          n_checks = 0;
  wire         i_mem_ack;
  wire  [31:0] i_mem_rdata;
  wire  [31:0] o_port_rdata, o_mem_addr, o_mem_wdata, o_card_tx_data;
  wire         o_mem_req, o_mem_we, o_card_tx_valid, o_card_rx_ready;
  wire         o_busy, o_suspended, o_tx_done_flag, o_rx_done_flag;
  wire         o_desc_unavail, o_count_error, o_card_fault_summary;

  cdma_engine i_cdma_engine (.*);
  chdd_host_mem i_chdd_host_mem (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_req     (o_mem_req),
    .i_we      (o_mem_we),
    .i_addr    (o_mem_addr),
    .i_wdata   (o_mem_wdata),
    .o_ack     (i_mem_ack),
    .o_rdata   (i_mem_rdata),
    .i_wait    (mem_wait)
  );

  initial forever #2.5 i_mclk = ~i_mclk;

  // Card side: capture sends, feed a counting receive stream
  always @(posedge i_mclk) begin
    if (o_card_tx_valid && i_card_tx_ready)
      txq.push_back(o_card_tx_data);
    rx_take = i_card_rx_valid && o_card_rx_ready;
    #1;
    i_card_tx_ready = !stall || !i_card_tx_ready;
    if (rx_take)
      i_card_rx_data = i_card_rx_data + 32'h1;
  end

  // ----------
  // Helpers
  // ----------
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic put(input int a, input logic [31:0] w0, w1, w2, w3);
    i_chdd_host_mem.mem[a] = w0;
    i_chdd_host_mem.mem[a + 1] = w1;
    i_chdd_host_mem.mem[a + 2] = w2;
    i_chdd_host_mem.mem[a + 3] = w3;
  endtask

  task automatic start(input logic [31:0] count);
    i_byte_count = count;
    i_dma_start = 1'b1;
    tick;
    i_dma_start = 1'b0;
    repeat (3) tick;
  endtask

  task automatic finish_run(input int words);
    repeat (800) if (o_busy) tick;
    repeat (60) if (txq.size() < words) tick;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic test_tx_chain;
    put(0, 32'h8000_0018, 32'h0000_0008, 32'h0000_0080, 32'h0000_0040);
    put(16, 32'h8000_0004, 32'h0000_0004, 32'h0000_00A0, 32'h0000_0000);
    i_chdd_host_mem.mem[32] = 32'h1111_1111;
    i_chdd_host_mem.mem[33] = 32'h2222_2222;
    i_chdd_host_mem.mem[40] = 32'h3333_3333;
    mem_wait = 2'h3;
    stall = 1'b1;
    i_raw_card_events = 7'h01;
    i_cmd_done = 1'b0;
    start(32'h0000_000C);
    repeat (40) tick;
    check(txq.size(), 0);
    i_cmd_done = 1'b1;
    i_transfer_request = 1'b0;
    repeat (40) tick;
    check(txq.size(), 0);
    i_transfer_request = 1'b1;
    finish_run(3);
    check(txq.size(), 3);
    check(txq[0], 32'h1111_1111);
    check(txq[1], 32'h2222_2222);
    check(txq[2], 32'h3333_3333);
    check(i_chdd_host_mem.mem[0], 32'h4000_0018);
    check(i_chdd_host_mem.mem[16], 32'h4000_0004);
    check(32'(o_tx_done_flag), 32'h1);
    check(32'(o_count_error), 32'h0);
    $display("test tx_chain done, mismatches %0d", n_mismatch);
  endtask

  task automatic test_suspend;
    i_done_clear = 1'b1;
    tick;
    i_done_clear = 1'b0;
    check(32'(o_tx_done_flag), 32'h0);
    txq.delete();
    stall = 1'b0;
    mem_wait = 2'h0;
    i_raw_card_events = 7'h00;
    put(0, 32'h0000_0008, 32'h0000_0000, 32'h0000_0080, 32'h0000_0000);
    put(4, 32'h8000_0026, 32'h0000_0004, 32'h0000_00A0, 32'h0000_0000);
    i_chdd_host_mem.mem[40] = 32'h4444_4444;
    start(32'h0000_0004);
    repeat (200) if (!o_suspended) tick;
    check(32'(o_desc_unavail), 32'h1);
    check(txq.size(), 0);
    i_chdd_host_mem.mem[0] = 32'h8000_0008;
    i_unavail_clear = 1'b1;
    i_poll_demand_kick = 1'b1;
    tick;
    i_unavail_clear = 1'b0;
    i_poll_demand_kick = 1'b0;
    finish_run(1);
    check(txq.size(), 1);
    check(txq[0], 32'h4444_4444);
    check(i_chdd_host_mem.mem[0], 32'h0000_0008);
    check(i_chdd_host_mem.mem[4], 32'h0000_0026);
    check(32'(o_tx_done_flag), 32'h0);
    check(32'(o_desc_unavail), 32'h0);
    $display("test suspend done, mismatches %0d", n_mismatch);
  endtask

  task automatic test_rx_ring;
    // Traps at word 0 and 12 are reached only by a wrong next entry
    put(0, 32'h8000_0004, 32'h0000_0004, 32'h0000_00A0, 32'h0000_0000);
    put(8, 32'h8000_0020, 32'h0000_0008, 32'h0000_0080, 32'h0000_0000);
    put(12, 32'h8000_0004, 32'h0000_0004, 32'h0000_00A0, 32'h0000_0000);
    i_list_base = 32'h0000_0020;
    i_dir_rx = 1'b1;
    i_raw_card_events = 7'h40;
    exp = i_card_rx_data;
    i_card_rx_valid = 1'b1;
    start(32'h0000_0008);
    repeat (400) if (!o_suspended) tick;
    check(32'(o_suspended), 32'h1);
    check(i_chdd_host_mem.mem[32], exp);
    check(i_chdd_host_mem.mem[33], exp + 32'h1);
    check(i_chdd_host_mem.mem[8], 32'h4000_0020);
    check(i_chdd_host_mem.mem[12], 32'h8000_0004);
    check(i_chdd_host_mem.mem[0], 32'h8000_0004);
    check(32'(o_rx_done_flag), 32'h0);
    i_card_rx_valid = 1'b0;
    i_raw_card_events = 7'h00;
    i_dir_rx = 1'b0;
    i_reset_n = 1'b0;
    tick;
    i_reset_n = 1'b1;
    check({30'h0, o_busy, o_suspended}, 32'h0);
    $display("test rx_ring done, mismatches %0d", n_mismatch);
  endtask

  task automatic test_port;
    txq.delete();
    repeat (3) tick;
    i_send_enable = 1'b1;
    i_port_wr = 1'b1;
    i_port_wdata = 32'hA5A5_5A5A;
    tick;
    i_send_enable = 1'b0;
    i_port_wdata = 32'h0F0F_0F0F;
    tick;
    i_port_wr = 1'b0;
    repeat (20) tick;
    check(txq.size(), 1);
    check(txq[0], 32'hA5A5_5A5A);
    exp = i_card_rx_data;
    i_card_rx_valid = 1'b1;
    tick;
    i_card_rx_valid = 1'b0;
    repeat (3) tick;
    i_port_rd = 1'b1;
    tick;
    i_port_rd = 1'b0;
    check(o_port_rdata, exp);
    $display("test port done, mismatches %0d", n_mismatch);
  endtask

  initial begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge i_mclk);
    #1;
    i_reset_n = 1'b1;
    test_tx_chain;
    test_suspend;
    test_rx_ring;
    test_port;
    report_and_stop;
  end
endmodule

// File: verification/chdd_checker.sv
// Purpose: Port checks on the descriptor DMA engine
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every engine instance
`timescale 1ns/1ps
`include "cdma_regs.vh"

module chdd_checker (
  // Clock, reset and control
  input wire                    i_mclk,
  input wire                    i_reset_n,
  input wire                    i_dma_start,
  input wire [31:0]             i_list_base,
  input wire                    i_dir_rx,
  input wire                    i_poll_demand_kick,
  input wire                    i_done_clear,
  input wire                    i_unavail_clear,
  input wire [`CDMA_NFAULT-1:0] i_raw_card_events,
  // Memory and card handshakes
  input wire                    i_mem_ack,
  input wire                    i_card_tx_ready,
  input wire                    o_mem_req,
  input wire                    o_mem_we,
  input wire [31:0]             o_mem_addr,
  input wire [31:0]             o_mem_wdata,
  input wire                    o_card_tx_valid,
  input wire [31:0]             o_card_tx_data,
  // Status
  input wire                    o_busy,
  input wire                    o_suspended,
  input wire                    o_tx_done_flag,
  input wire                    o_desc_unavail,
  input wire                    o_card_fault_summary
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  a_req_hold: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
    && $stable(o_mem_we)) else $error("memory request changed early");
  a_req_release: assert property (
    o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("memory request held past ack");
  a_start_fetch: assert property (
    i_dma_start && !o_busy |-> ##2 o_mem_req && !o_mem_we
    && o_mem_addr == $past(i_list_base, 2))
    else $error("first fetch not at list base");
  a_owner_clear: assert property (
    o_mem_req && o_mem_we && !i_dir_rx |-> !o_mem_wdata[31])
    else $error("write back keeps owner bit");
  a_fault_copy: assert property (
    o_mem_req && o_mem_we && !i_dir_rx && !$past(o_mem_req)
    |-> o_mem_wdata[30] == $past(o_card_fault_summary))
    else $error("write back lost fault summary");
  a_fault_set: assert property (
    |i_raw_card_events |=> o_card_fault_summary)
    else $error("card fault not summarised");
  a_tx_hold: assert property (
    o_card_tx_valid && !i_card_tx_ready |=> o_card_tx_valid
    && $stable(o_card_tx_data)) else $error("card word dropped");
  a_susp_quiet: assert property (
    o_suspended |-> !o_mem_req) else $error("memory access in suspend");
  a_susp_flag: assert property (
    $rose(o_suspended) |-> ##[0:2] o_desc_unavail)
    else $error("suspend without unavailable flag");
  a_kick_fetch: assert property (
    o_suspended && i_poll_demand_kick |-> ##[1:4] o_mem_req && !o_mem_we)
    else $error("kick did not refetch");
  a_done_hold: assert property (
    o_tx_done_flag && !i_done_clear |=> o_tx_done_flag)
    else $error("done flag lost");
endmodule

bind cdma_engine chdd_checker i_chdd_checker (.*);

// File: verification/chdd_host_mem.sv
// Purpose: Host memory holding list entries and data buffers
// Assumes: Engine holds its request until acknowledged
// Notes:   Bench sets the answer delay and fills memory directly
`timescale 1ns/1ps

module chdd_host_mem (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_reset_n,
  // Memory slave
  input  wire        i_req,
  input  wire        i_we,
  input  wire [31:0] i_addr,
  input  wire [31:0] i_wdata,
  output reg         o_ack,
  output reg  [31:0] o_rdata,
  // Bench control
  input  wire [1:0]  i_wait
);
  reg  [31:0] mem [0:63];
  reg  [1:0]  wait_cnt;
  wire        take = i_req && !o_ack && wait_cnt == i_wait;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack    <= 1'b0;
      wait_cnt <= 2'h0;
      o_rdata  <= 32'h0;
    end else begin
      o_ack    <= take;
      wait_cnt <= (i_req && !o_ack && !take) ? wait_cnt + 2'h1 : 2'h0;
      // one word per four byte addresses, indexed by i_addr[7:2]
      // Idle read lines toggle so stale data never looks valid
      o_rdata  <= (take && !i_we) ? mem[i_addr[7:2]] : ~o_rdata;
      if (take && i_we)
        mem[i_addr[7:2]] <= i_wdata;
    end
  end
endmodule
